// *** video_rx_path.sv ***
// Receive video path: lane merge, lock, decode, decrypt, delay, display lane packing.
`timescale 1ns/100ps
`default_nettype none
`include "video_path_regs.svh"
module video_rx_path #(
    parameter logic [23:0] CIPHER_KEY = `KEY_DEFAULT
) (
    input wire logic clk,
    input wire logic rst,
    input wire video_path_pkg::symbol_t lane0_sym,
    input wire logic lane0_vld,
    input wire video_path_pkg::symbol_t lane1_sym,
    input wire logic lane1_vld,
    input wire logic two_lane_pin,
    input wire logic dual_out_pin,
    input wire logic cipher_en_pin,
    input wire logic [7:0] bcc_rev_byte,
    input wire logic bcc_rev_valid,
    output logic bcc_rev_ready,
    output logic back_tx,
    output logic [7:0] bcc_fwd_byte,
    output logic bcc_fwd_stb,
    output logic lock,
    output video_path_pkg::out_word_t ch0_word,
    output logic ch0_load,
    output video_path_pkg::out_word_t ch1_word,
    output logic ch1_load,
    output logic [6:0] clk_lane_word,
    output logic [3:0] audio_out
);
    import video_path_pkg::*;

    // Even parity over the whole symbol marks a symbol as valid.
    function automatic logic sym_ok(input symbol_t s);
        sym_ok = ~(^s);
    endfunction : sym_ok

    // Pixel rate in MHz for a given line rate.
    function automatic int pix_mhz(input int rate_mbps);
        pix_mhz = rate_mbps / `SYM_BITS;
    endfunction : pix_mhz

    localparam int PIX1_MAX_MHZ = pix_mhz(`LINE_RATE_1L_MBPS);
    localparam int PIX2_MAX_MHZ = 2 * pix_mhz(`LINE_RATE_2L_MBPS);
    localparam int DELAY_DEPTH = `LATENCY_T - `PIPE_STAGES;

    // Strap pins cross in from the board.
    logic [2:0] pin_m_r;
    logic [2:0] pin_s_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_m_r <= '0;
            pin_s_r <= '0;
        end else begin
            pin_m_r <= {cipher_en_pin, dual_out_pin, two_lane_pin};
            pin_s_r <= pin_m_r;
        end
    end
    logic two_lane;
    logic dual_out;
    logic cipher_en;
    assign two_lane = pin_s_r[0];
    assign dual_out = pin_s_r[1];
    assign cipher_en = pin_s_r[2];

    // Lane merge and lock.
    lock_state_t lk_r;
    lock_state_t lk_nxt;
    logic [4:0] good_r;
    logic [4:0] good_nxt;
    logic [2:0] bad_r;
    logic [2:0] bad_nxt;
    logic slot_r;
    logic slot_nxt;
    symbol_t cur_sym;
    logic cur_vld;
    logic acc;

    always_comb begin
        // In two-lane mode each lane fills every other slot, half the pixel rate.
        cur_sym = (two_lane && slot_r) ? lane1_sym : lane0_sym;
        cur_vld = (two_lane && slot_r) ? lane1_vld : lane0_vld;
        slot_nxt = two_lane ? ~slot_r : 1'b0;
        lk_nxt = lk_r;
        good_nxt = good_r;
        bad_nxt = bad_r;
        // Lock comes from parity alone, so any payload pattern will do.
        if (cur_vld) begin
            case (lk_r)
                LK_HUNT: begin
                    good_nxt = sym_ok(cur_sym) ? good_r + 1'b1 : '0;
                    if (sym_ok(cur_sym) && good_r == `LOCK_GOOD_CNT - 1'b1) begin
                        lk_nxt = LK_LOCKED;
                        good_nxt = '0;
                    end
                    bad_nxt = '0;
                end
                LK_LOCKED: begin
                    bad_nxt = sym_ok(cur_sym) ? '0 : bad_r + 1'b1;
                    if (!sym_ok(cur_sym) && bad_r == `LOCK_BAD_CNT - 1'b1) begin
                        lk_nxt = LK_HUNT;
                        bad_nxt = '0;
                    end
                end
                default: lk_nxt = LK_HUNT;
            endcase
        end
        acc = cur_vld && sym_ok(cur_sym) && lk_r == LK_LOCKED;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lk_r <= LK_HUNT;
            good_r <= '0;
            bad_r <= '0;
            slot_r <= 1'b0;
        end else begin
            lk_r <= lk_nxt;
            good_r <= good_nxt;
            bad_r <= bad_nxt;
            slot_r <= slot_nxt;
        end
    end

    // Stage one holds the checked symbol; stage two the decoded, decrypted pixel.
    symbol_t s1_sym_r;
    logic s1_vld_r;
    logic [31:0] s2_r;
    logic [31:0] s2_nxt;
    logic [23:0] ks_r;
    logic [23:0] ks_nxt;
    logic [`NONCE_BITS-1:0] nonce_r;
    logic [`NONCE_BITS-1:0] nonce_nxt;
    logic [7:0] fwd_sh_r;
    logic [7:0] fwd_sh_nxt;
    logic [3:0] fwd_cnt_r;
    logic [3:0] fwd_cnt_nxt;
    logic [7:0] fwd_byte_r;
    logic [7:0] fwd_byte_nxt;
    logic fwd_stb_r;
    logic fwd_stb_nxt;

    always_comb begin
        s2_nxt = '0;
        ks_nxt = ks_r;
        nonce_nxt = nonce_r;
        fwd_sh_nxt = fwd_sh_r;
        fwd_cnt_nxt = fwd_cnt_r;
        fwd_byte_nxt = fwd_byte_r;
        fwd_stb_nxt = 1'b0;
        // Keystream restarts from the on-chip key mixed with the exchanged nonce.
        if (!cipher_en) begin
            ks_nxt = CIPHER_KEY ^ nonce_r;
        end
        if (s1_vld_r) begin
            // Cipher sits after field extraction and ahead of the output.
            s2_nxt[23:0] = s1_sym_r[23:0] ^ (cipher_en ? ks_r : 24'h000000);
            s2_nxt[26:24] = s1_sym_r[`SYM_CTRL_LSB +: `CTRL_BITS];
            s2_nxt[30:27] = s1_sym_r[`SYM_AUDIO_LSB +: `AUDIO_BITS]
                ^ (cipher_en ? ks_r[3:0] : 4'h0);
            s2_nxt[31] = 1'b1;
            if (cipher_en) begin
                ks_nxt = {ks_r[22:0], ks_r[23] ^ ks_r[22] ^ ks_r[21] ^ ks_r[16]};
            end
            // One control-channel bit rides in every forward symbol.
            fwd_sh_nxt = {s1_sym_r[`SYM_BCC_BIT], fwd_sh_r[7:1]};
            fwd_cnt_nxt = fwd_cnt_r + 1'b1;
            if (fwd_cnt_r == `BCC_BYTE_BITS - 1'b1) begin
                fwd_cnt_nxt = '0;
                fwd_byte_nxt = fwd_sh_nxt;
                fwd_stb_nxt = 1'b1;
                // While the cipher is idle, channel bytes carry the key exchange.
                if (!cipher_en) begin
                    nonce_nxt = {nonce_r[`NONCE_BITS-9:0], fwd_sh_nxt};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_sym_r <= '0;
            s1_vld_r <= 1'b0;
            s2_r <= '0;
            ks_r <= CIPHER_KEY;
            nonce_r <= '0;
            fwd_sh_r <= '0;
            fwd_cnt_r <= '0;
            fwd_byte_r <= '0;
            fwd_stb_r <= 1'b0;
        end else begin
            s1_sym_r <= cur_sym;
            s1_vld_r <= acc;
            s2_r <= s2_nxt;
            ks_r <= ks_nxt;
            nonce_r <= nonce_nxt;
            fwd_sh_r <= fwd_sh_nxt;
            fwd_cnt_r <= fwd_cnt_nxt;
            fwd_byte_r <= fwd_byte_nxt;
            fwd_stb_r <= fwd_stb_nxt;
        end
    end

    logic [31:0] dly_out;
    pixel_delay_line #(
        .WIDTH(32),
        .DEPTH(DELAY_DEPTH)
    ) u_delay (
        .clk(clk),
        .rst(rst),
        .din(s2_r),
        .dout(dly_out)
    );

    // Output packing: lane k holds bits 7k..7k+6, element 0 leaves first.
    out_word_t ch0_r;
    out_word_t ch0_nxt;
    out_word_t ch1_r;
    out_word_t ch1_nxt;
    logic ld0_r;
    logic ld0_nxt;
    logic ld1_r;
    logic ld1_nxt;
    logic sel_r;
    logic sel_nxt;
    logic [3:0] aud_r;
    logic [3:0] aud_nxt;

    always_comb begin
        ch0_nxt = ch0_r;
        ch1_nxt = ch1_r;
        ld0_nxt = 1'b0;
        ld1_nxt = 1'b0;
        sel_nxt = dual_out ? sel_r : 1'b0;
        aud_nxt = aud_r;
        if (dly_out[31]) begin
            aud_nxt = dly_out[30:27];
            // Odd pixels go to the second channel only in dual mode.
            if (dual_out && sel_r) begin
                ch1_nxt = {1'b0, dly_out[26:0]};
                ld1_nxt = 1'b1;
            end else begin
                ch0_nxt = {1'b0, dly_out[26:0]};
                ld0_nxt = 1'b1;
            end
            sel_nxt = dual_out ? ~sel_r : 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ch0_r <= '0;
            ch1_r <= '0;
            ld0_r <= 1'b0;
            ld1_r <= 1'b0;
            sel_r <= 1'b0;
            aud_r <= '0;
        end else begin
            ch0_r <= ch0_nxt;
            ch1_r <= ch1_nxt;
            ld0_r <= ld0_nxt;
            ld1_r <= ld1_nxt;
            sel_r <= sel_nxt;
            aud_r <= aud_nxt;
        end
    end

    // Reverse channel: slow start-data-stop frames; idle line sits high.
    logic [9:0] rev_sh_r;
    logic [9:0] rev_sh_nxt;
    logic [3:0] rev_cnt_r;
    logic [3:0] rev_cnt_nxt;
    logic [7:0] div_r;
    logic [7:0] div_nxt;

    always_comb begin
        rev_sh_nxt = rev_sh_r;
        rev_cnt_nxt = rev_cnt_r;
        div_nxt = div_r;
        bcc_rev_ready = (rev_cnt_r == 4'h0);
        if (bcc_rev_valid && bcc_rev_ready) begin
            rev_sh_nxt = {1'b1, bcc_rev_byte, 1'b0};
            rev_cnt_nxt = `BCC_FRAME_BITS;
            div_nxt = '0;
        end else if (rev_cnt_r != 4'h0) begin
            div_nxt = div_r + 1'b1;
            if (div_r == `BACK_DIV - 1'b1) begin
                div_nxt = '0;
                rev_sh_nxt = {1'b1, rev_sh_r[9:1]};
                rev_cnt_nxt = rev_cnt_r - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rev_sh_r <= '1;
            rev_cnt_r <= '0;
            div_r <= '0;
        end else begin
            rev_sh_r <= rev_sh_nxt;
            rev_cnt_r <= rev_cnt_nxt;
            div_r <= div_nxt;
        end
    end

    assign back_tx = rev_sh_r[0];
    assign bcc_fwd_byte = fwd_byte_r;
    assign bcc_fwd_stb = fwd_stb_r;
    assign lock = (lk_r == LK_LOCKED);
    assign ch0_word = ch0_r;
    assign ch0_load = ld0_r;
    assign ch1_word = ch1_r;
    assign ch1_load = ld1_r;
    assign clk_lane_word = `CLK_LANE_PATTERN;
    assign audio_out = aud_r;

    // Checks.
    logic [7:0] up_cnt_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            up_cnt_r <= '0;
        end else if (up_cnt_r != 8'hff) begin
            up_cnt_r <= up_cnt_r + 1'b1;
        end
    end

    chk_latency_exact: assert property (@(posedge clk) disable iff (rst)
        up_cnt_r > 8'h96 |-> ((ld0_r || ld1_r) == $past(acc, `LATENCY_T)))
        else $error("pixel output not 147 clocks after symbol accept");
    chk_bad_symbol_drop: assert property (@(posedge clk) disable iff (rst)
        cur_vld && !sym_ok(cur_sym) |=> !s1_vld_r)
        else $error("invalid symbol passed the check stage");
    // Channel of the last load; outside dual mode it reads as channel 1 so the first dual
    // pixel is expected on channel 0.
    logic alt_last_r;
    always_ff @(posedge clk) begin
        if (rst || !dual_out) begin
            alt_last_r <= 1'b1;
        end else if (ld0_r || ld1_r) begin
            alt_last_r <= ld1_r;
        end
    end
    chk_dual_alternate: assert property (@(posedge clk) disable iff (rst)
        dual_out && $past(dual_out) && $past(dual_out, 2) && (ld0_r || ld1_r)
        |-> ld1_r == !alt_last_r)
        else $error("dual output did not alternate channels");
    chk_single_ch0: assert property (@(posedge clk) disable iff (rst)
        !dual_out && $past(!dual_out) |-> !ld1_r)
        else $error("second channel loaded in single mode");
    chk_lock_gain: assert property (@(posedge clk) disable iff (rst)
        lk_r == LK_HUNT ##1 lk_r == LK_LOCKED |-> $past(good_r) == `LOCK_GOOD_CNT - 1'b1)
        else $error("lock gained without the good-symbol run");
    chk_two_lane_slot: assert property (@(posedge clk) disable iff (rst)
        two_lane && $past(two_lane) |-> slot_r != $past(slot_r))
        else $error("two-lane slots did not alternate");
    chk_rev_frame: assert property (@(posedge clk) disable iff (rst)
        bcc_rev_valid && bcc_rev_ready |=> !back_tx ##1 !bcc_rev_ready[*3])
        else $error("reverse frame missing start bit or ready");
    chk_plain_bypass: assert property (@(posedge clk) disable iff (rst)
        !cipher_en && s1_vld_r |=> s2_r[23:0] == $past(s1_sym_r[23:0]))
        else $error("pixel altered while cipher is off");

    cov_lock: cover property (@(posedge clk) disable iff (rst) $rose(lock));
    cov_dual: cover property (@(posedge clk) disable iff (rst) ld1_r);
    cov_fwd_byte: cover property (@(posedge clk) disable iff (rst) bcc_fwd_stb);
    cov_rev_done: cover property (@(posedge clk) disable iff (rst) $rose(bcc_rev_ready));
endmodule : video_rx_path
`default_nettype wire

// *** video_path_regs.svh ***
// Named constants of the receive video path.
`ifndef VIDEO_PATH_REGS_SVH
`define VIDEO_PATH_REGS_SVH

`define SYM_BITS 35
`define SYM_PARITY_BIT 34
`define SYM_BCC_BIT 31
`define SYM_AUDIO_LSB 27
`define SYM_CTRL_LSB 24
`define RGB_BITS 24
`define CTRL_BITS 3
`define AUDIO_BITS 4
`define LINE_RATE_1L_MBPS 3360
`define LINE_RATE_2L_MBPS 2975
`define LANE_UI_BITS 7
`define OUT_LANES 4
`define OUT_WORD_BITS 28
`define CLK_LANE_PATTERN 7'h63
`define LATENCY_T 147
`define PIPE_STAGES 4
`define LOCK_GOOD_CNT 5'h10
`define LOCK_BAD_CNT 3'h4
`define BCC_BYTE_BITS 4'h8
`define BCC_FRAME_BITS 4'ha
`define BACK_DIV 8'h04
`define KEY_DEFAULT 24'h5a3c96
`define NONCE_BITS 24

`endif

// *** video_path_pkg.sv ***
// Types shared by the receive video path.
package video_path_pkg;
    typedef enum logic [0:0] {LK_HUNT, LK_LOCKED} lock_state_t;
    typedef logic [34:0] symbol_t;
    typedef logic [27:0] out_word_t;
endpackage : video_path_pkg

// *** pixel_delay_line.sv ***
// Fixed-length delay line that carries decoded pixels toward the output.
`timescale 1ns/100ps
`default_nettype none
module pixel_delay_line #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 143
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [$clog2(DEPTH)-1:0] ptr_r;
    logic [$clog2(DEPTH)-1:0] ptr_nxt;
    logic [WIDTH-1:0] dout_r;
    logic filled_r;
    logic filled_nxt;

    // Reset clears only the memory slot at the pointer, so slots ahead of the pointer still carry pixels from before
    // reset; the fill flag blanks the output until the pointer has wrapped once.
    always_comb begin
        ptr_nxt = (ptr_r == $clog2(DEPTH)'(DEPTH - 1)) ? '0 : ptr_r + 1'b1;
        filled_nxt = filled_r | (ptr_r == $clog2(DEPTH)'(DEPTH - 1));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_r <= '0;
            dout_r <= '0;
            filled_r <= 1'b0;
        end else begin
            ptr_r <= ptr_nxt;
            dout_r <= filled_r ? mem[ptr_r] : '0;
            filled_r <= filled_nxt;
        end
        mem[ptr_r] <= rst ? '0 : din;
    end

    assign dout = dout_r;
endmodule : pixel_delay_line
`default_nettype wire

// *** serializer_model.sv ***
// Serializer partner model: sends forward symbols and decodes reverse frames.
`timescale 1ns/100ps
`default_nettype none
module serializer_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic send,
    input wire logic two_lane,
    input wire logic bad,
    input wire logic back_tx,
    output var video_path_pkg::symbol_t lane0_sym,
    output var logic lane0_vld,
    output var video_path_pkg::symbol_t lane1_sym,
    output var logic lane1_vld,
    output var logic [7:0] rev_byte,
    output var logic rev_stb
);
    import video_path_pkg::*;
    logic slot_r = 1'b0;
    logic rs;
    logic go;
    logic flip;
    logic hi;
    int n_r = 0;
    int rx_n = -1;
    logic [9:0] rx_sh = 10'h0;
    symbol_t s;
    initial begin
        lane0_sym = 35'h0;
        lane1_sym = 35'h0;
        lane0_vld = 1'b0;
        lane1_vld = 1'b0;
        rev_byte = 8'h0;
        rev_stb = 1'b0;
    end
    always @(posedge clk) begin
        rs = rst;
        go = send & ~rst;
        flip = bad;
        #1;
        slot_r = ~rs & ~slot_r;
        // Pixel data changes every symbol, so lock cannot lean on a fixed pattern.
        s = {1'b0, 2'h0, 1'(8'h1d >> (n_r % 8)), 4'(n_r * 5), 3'(n_r), 24'(n_r * 32'h9e3779)};
        s[34] = ^s[33:0] ^ flip;
        n_r = rs ? 0 : n_r + int'(go);
        hi = go & two_lane & slot_r;
        lane0_vld = go & ~hi;
        lane1_vld = hi;
        // An idle lane flips every cycle rather than hold a stale symbol.
        lane0_sym = lane0_vld ? s : ~lane0_sym;
        lane1_sym = hi ? s : ~lane1_sym;
        rev_stb = 1'b0;
        if (rs || (rx_n < 0 && back_tx)) rx_n = -1;
        else rx_n++;
        if (rx_n % 4 == 2) rx_sh = {back_tx, rx_sh[9:1]};
        if (rx_n == 38) begin
            // Only a frame with a low start and a high stop counts as received.
            rev_stb = ~rx_sh[0] & rx_sh[9];
            rev_byte = rx_sh[8:1];
            rx_n = -1;
        end
    end
endmodule : serializer_model
`default_nettype wire

// *** serial_video_deserializer_path_tb.sv ***
// Testbench of the receive video path against a serializer model.
`timescale 1ns/100ps
`default_nettype none
`include "video_path_regs.svh"
module serial_video_deserializer_path_tb;
    import video_path_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic send = 1'b0;
    logic bad = 1'b0;
    logic two = 1'b0;
    logic dual = 1'b0;
    logic ciph = 1'b0;
    logic [7:0] fwd_sh = 8'h0;
    int fwd_bits = 0;
    logic [7:0] fwd_q[$];
    logic [3:0] q_a[$];
    logic nxt_ch = 1'b0;
    logic [7:0] rev_b = 8'h0;
    logic rev_v = 1'b0;
    symbol_t l0_s, l1_s, mon_s;
    logic l0_v, l1_v, rev_rdy, back_tx, fwd_stb, lock, ld0, ld1, m_stb;
    logic [7:0] fwd_b, m_byte;
    out_word_t w0, w1;
    logic [6:0] clkw;
    logic [3:0] aud;
    int err_total = 0;
    int compares = 0;
    int edge_n = 0;
    int diffs = 0;
    int fwd_n = 0;
    int q_c[$];
    out_word_t q_w[$];
    logic q_ch[$];
    logic [7:0] rev_q[$];

    always #50 clk = ~clk;

    video_rx_path DUT (
        .clk(clk), .rst(rst), .lane0_sym(l0_s), .lane0_vld(l0_v),
        .lane1_sym(l1_s), .lane1_vld(l1_v), .two_lane_pin(two), .dual_out_pin(dual),
        .cipher_en_pin(ciph), .bcc_rev_byte(rev_b), .bcc_rev_valid(rev_v),
        .bcc_rev_ready(rev_rdy), .back_tx(back_tx), .bcc_fwd_byte(fwd_b),
        .bcc_fwd_stb(fwd_stb), .lock(lock), .ch0_word(w0), .ch0_load(ld0),
        .ch1_word(w1), .ch1_load(ld1), .clk_lane_word(clkw), .audio_out(aud)
    );

    serializer_model partner (
        .clk(clk), .rst(rst), .send(send), .two_lane(two), .bad(bad),
        .back_tx(back_tx), .lane0_sym(l0_s), .lane0_vld(l0_v), .lane1_sym(l1_s),
        .lane1_vld(l1_v), .rev_byte(m_byte), .rev_stb(m_stb)
    );

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // A wait that ran out of its bound ends the run at once.
    task automatic must(input logic [63:0] seen, input logic [63:0] exp);
        check(seen, exp);
        if (seen !== exp) results();
    endtask : must

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic take(input logic ch, input out_word_t w);
        out_word_t e;
        logic [3:0] a;
        if (q_c.size() == 0) begin
            check(64'h1, 64'h0);
            return;
        end
        e = q_w.pop_front();
        a = q_a.pop_front();
        if (!ciph) check(64'(aud), 64'(a));
        check(64'(edge_n - q_c.pop_front()), 64'(`LATENCY_T));
        check(64'(ch), 64'(q_ch.pop_front()));
        check(64'(w[27:24]), 64'(e[27:24]));
        if (ciph) diffs += int'(w[23:0] !== e[23:0]);
        else check(64'(w), 64'(e));
    endtask : take

    // Every good symbol seen while locked must come out once, in order.
    always @(posedge clk) begin
        edge_n++;
        mon_s = l1_v ? l1_s : l0_s;
        if (rst) begin
            nxt_ch = 1'b0;
            fwd_bits = 0;
        end else if ((l0_v | l1_v) && !(^mon_s) && lock === 1'b1) begin
            q_c.push_back(edge_n);
            q_w.push_back({1'b0, mon_s[26:0]});
            q_a.push_back(mon_s[30:27]);
            q_ch.push_back(nxt_ch);
            nxt_ch = dual & ~nxt_ch;
            // Each accepted symbol adds one control bit; the first lands in the byte's LSB.
            fwd_sh = {mon_s[31], fwd_sh[7:1]};
            fwd_bits++;
            if (fwd_bits == 8) begin
                fwd_q.push_back(fwd_sh);
                fwd_bits = 0;
            end
        end
        if (ld0 === 1'b1) take(1'b0, w0);
        if (ld1 === 1'b1) take(1'b1, w1);
        if (fwd_stb === 1'b1) check(64'(fwd_b), fwd_q.size() ? 64'(fwd_q.pop_front()) : 64'h1ff);
        fwd_n += int'(fwd_stb === 1'b1);
        if (m_stb === 1'b1) check(64'(m_byte), rev_q.size() ? 64'(rev_q.pop_front()) : 64'h1ff);
    end

    task automatic restart(input logic t, input logic d, input logic c);
        send = 1'b0;
        two = t;
        dual = d;
        ciph = c;
        diffs = 0;
        rst = 1'b1;
        tick(4);
        rst = 1'b0;
    endtask : restart

    task automatic wait_lock(input logic want);
        int i;
        for (i = 0; i < 40 && lock !== want; i++) tick(1);
        must(64'(lock), 64'(want));
    endtask : wait_lock

    task automatic drain();
        send = 1'b0;
        tick(160);
        check(64'(q_c.size()), 64'h0);
        check(64'(fwd_q.size()), 64'h0);
    endtask : drain

    task automatic mode_run(input logic t, input logic d, input logic c);
        restart(t, d, c);
        send = 1'b1;
        tick(12);
        check(64'(lock), 64'h0);
        wait_lock(1'b1);
        tick(200);
        drain();
        check(64'(clkw), 64'(`CLK_LANE_PATTERN));
        if (c) check(64'(diffs > 0), 64'h1);
    endtask : mode_run

    // A lone bad symbol is dropped; four in a row drop lock until relock.
    task automatic parity_run();
        restart(1'b0, 1'b0, 1'b0);
        send = 1'b1;
        wait_lock(1'b1);
        tick(20);
        bad = 1'b1;
        tick(1);
        bad = 1'b0;
        tick(20);
        check(64'(lock), 64'h1);
        bad = 1'b1;
        tick(4);
        bad = 1'b0;
        wait_lock(1'b0);
        wait_lock(1'b1);
        drain();
    endtask : parity_run

    task automatic rev_send(input logic [7:0] b);
        int i;
        rev_b = b;
        rev_v = 1'b1;
        for (i = 0; i < 60 && rev_rdy !== 1'b1; i++) tick(1);
        must(64'(rev_rdy), 64'h1);
        tick(1);
        rev_q.push_back(b);
        check(64'({back_tx, rev_rdy}), 64'h0);
        rev_v = 1'b0;
        tick(1);
    endtask : rev_send

    // Two bytes offered back to back; the second waits out the first frame.
    task automatic rev_run();
        int i;
        restart(1'b0, 1'b0, 1'b0);
        check(64'({back_tx, rev_rdy}), 64'h3);
        rev_send(8'ha6);
        rev_send(8'h1b);
        for (i = 0; i < 100 && rev_q.size() > 0; i++) tick(1);
        must(64'(rev_q.size()), 64'h0);
    endtask : rev_run

    initial begin
        mode_run(1'b0, 1'b0, 1'b0);
        check(64'(fwd_n > 0), 64'h1);
        mode_run(1'b1, 1'b1, 1'b0);
        mode_run(1'b0, 1'b1, 1'b1);
        mode_run(1'b1, 1'b0, 1'b1);
        parity_run();
        rev_run();
        results();
    end
endmodule : serial_video_deserializer_path_tb
`default_nettype wire
